// >>> sse_exec.sv
// four-phase execution of literal and file subtracts and the sleep instruction
`timescale 1ns/1ps
`default_nettype none
module sse_exec (
	input  wire logic                        ref_clk,
	input  wire logic                        reset_n,
	input  wire logic [sse_pkg::INSTR_W-1:0] instr_word,
	input  wire logic                        acc_load_en,
	input  wire logic [sse_pkg::DATA_W-1:0]  acc_load_data,
	input  wire logic [sse_pkg::DATA_W-1:0]  file_rdata,
	input  wire logic                        wake,
	output logic      [sse_pkg::FADDR_W-1:0] file_addr,
	output logic      [sse_pkg::DATA_W-1:0]  file_wdata,
	output logic                             file_we,
	output logic      [sse_pkg::DATA_W-1:0]  acc,
	output sse_pkg::sse_flags_t              flags,
	output logic                             sleep_active,
	output sse_pkg::sse_phase_t              quarter
);

	sse_pkg::sse_phase_t               phase_q;
	sse_pkg::sse_op_t                  op_q;
	logic [sse_pkg::INSTR_W-1:0]       ir_q;
	logic [sse_pkg::DATA_W-1:0]        operand_q;
	logic [sse_pkg::DATA_W-1:0]        result_q;
	logic [sse_pkg::DATA_W-1:0]        acc_q;
	sse_pkg::sse_flags_t               flags_q;
	sse_pkg::sse_flags_t               calc_flags_q;
	logic                              sleep_pend_q;
	logic                              sleep_q;
	logic [sse_pkg::DATA_W-1:0]        diff_w;
	sse_pkg::sse_flags_t               flags_w;
	logic                              dest_file;

	assign dest_file    = ir_q[sse_pkg::DEST_BIT];
	assign file_addr    = ir_q[sse_pkg::FADDR_W-1:0];
	assign file_wdata   = result_q;
	assign acc          = acc_q;
	assign flags        = flags_q;
	assign sleep_active = sleep_q;
	assign quarter      = phase_q;

	// write strobe only in the fourth phase of a file op aimed at the file
	assign file_we = (phase_q == sse_pkg::PH_Q4) && (op_q == sse_pkg::OP_FILE) && dest_file;

	sse_subtractor u_sub (
		.minuend    (operand_q),
		.subtrahend (acc_q),
		.difference (diff_w),
		.flags      (flags_w)
	);

	// quarter-phase sequencer; it parks in Q1 while asleep so no instruction runs
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_q <= sse_pkg::PH_Q1;
		end else begin
			case (phase_q)
				sse_pkg::PH_Q1: phase_q <= sleep_q ? sse_pkg::PH_Q1 : sse_pkg::PH_Q2;
				sse_pkg::PH_Q2: phase_q <= sse_pkg::PH_Q3;
				sse_pkg::PH_Q3: phase_q <= sse_pkg::PH_Q4;
				default:        phase_q <= sse_pkg::PH_Q1;
			endcase
		end
	end

	// Q1: latch the instruction word and decode the subtracts
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ir_q <= sse_pkg::INSTR_RESET;
			op_q <= sse_pkg::OP_NONE;
		end else if (phase_q == sse_pkg::PH_Q1 && !sleep_q) begin
			ir_q <= instr_word;
			if (sse_pkg::is_lit_op(instr_word)) begin
				op_q <= sse_pkg::OP_LIT;
			end else if (sse_pkg::is_file_op(instr_word)) begin
				op_q <= sse_pkg::OP_FILE;
			end else begin
				op_q <= sse_pkg::OP_NONE;
			end
		end
	end

	// sleep does nothing in Q1, is decoded in Q2, idles in Q3
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_pend_q <= 1'b0;
		end else if (phase_q == sse_pkg::PH_Q2) begin
			sleep_pend_q <= sse_pkg::is_sleep_op(ir_q);
		end else if (phase_q == sse_pkg::PH_Q4) begin
			sleep_pend_q <= 1'b0;
		end
	end

	// Q4 enters sleep; wake only counts once asleep, so it cannot cancel a pending entry
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_q <= 1'b0;
		end else if (phase_q == sse_pkg::PH_Q4 && sleep_pend_q) begin
			sleep_q <= 1'b1;
		end else if (wake) begin
			sleep_q <= 1'b0;
		end
	end

	// Q2: fetch the minuend, either the literal byte or the addressed file register
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			operand_q <= sse_pkg::DATA_RESET;
		end else if (phase_q == sse_pkg::PH_Q2) begin
			if (op_q == sse_pkg::OP_LIT) begin
				operand_q <= ir_q[sse_pkg::DATA_W-1:0];
			end else begin
				operand_q <= file_rdata;
			end
		end
	end

	// Q3: compute the difference and the flags it implies
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			result_q     <= sse_pkg::DATA_RESET;
			calc_flags_q <= sse_pkg::FLAGS_RESET;
		end else if (phase_q == sse_pkg::PH_Q3) begin
			result_q     <= diff_w;
			calc_flags_q <= flags_w;
		end
	end

	// Q4: accumulator takes the result of a literal op, or of a file op not aimed at the file;
	// the side load is only honoured when no subtract is in flight, to avoid a race
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_q <= sse_pkg::ACC_RESET;
		end else if (phase_q == sse_pkg::PH_Q4 && op_q == sse_pkg::OP_LIT) begin
			acc_q <= result_q;
		end else if (phase_q == sse_pkg::PH_Q4 && op_q == sse_pkg::OP_FILE && !dest_file) begin
			acc_q <= result_q;
		end else if (acc_load_en && op_q == sse_pkg::OP_NONE) begin
			acc_q <= acc_load_data;
		end
	end

	// Q4: status flags follow both subtracts
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_q <= sse_pkg::FLAGS_RESET;
		end else if (phase_q == sse_pkg::PH_Q4 && op_q != sse_pkg::OP_NONE) begin
			flags_q <= calc_flags_q;
		end
	end

	// sleep is reached at the end of Q4, two phases after decode
	chk_sleep_entry: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q2 && sse_pkg::is_sleep_op(ir_q) && !sleep_q)
		|=> !sleep_q ##1 !sleep_q ##1 sleep_q)
		else $error("sleep not entered after Q4");

	chk_lit_acc_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q4 && op_q == sse_pkg::OP_LIT) |=> acc_q == $past(result_q))
		else $error("literal op did not write accumulator");

	chk_lit_no_file: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q4
		 && ir_q[sse_pkg::LIT_PFX_MSB:sse_pkg::LIT_PFX_LSB] == sse_pkg::LIT_PFX) |-> !file_we)
		else $error("literal op wrote a file register");

	chk_lit_value: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q2 && op_q == sse_pkg::OP_LIT)
		|=> ##1 result_q == ($past(ir_q[7:0], 2) - $past(acc_q, 2)))
		else $error("literal difference wrong");

	chk_zero_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q4 && op_q != sse_pkg::OP_NONE)
		|=> flags_q.zero == ($past(result_q) == 8'h00))
		else $error("zero flag does not match result");

	chk_borrow_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q3 && op_q != sse_pkg::OP_NONE && operand_q < acc_q)
		|=> ##1 !flags_q.carry)
		else $error("carry set despite borrow");

	chk_noborrow_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q3 && op_q != sse_pkg::OP_NONE && operand_q >= acc_q)
		|=> ##1 flags_q.carry)
		else $error("carry clear without borrow");

	chk_file_dest: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q4 && op_q == sse_pkg::OP_FILE)
		|-> (file_we == dest_file) ##1 (dest_file || acc_q == $past(result_q)))
		else $error("file op destination wrong");

	chk_file_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q1 && !sleep_q && instr_word[13:8] == 6'h02)
		|=> op_q == sse_pkg::OP_FILE ##2 phase_q == sse_pkg::PH_Q4)
		else $error("file op not decoded");

	chk_phase_order: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q1 && !sleep_q)
		|=> phase_q == sse_pkg::PH_Q2 ##1 phase_q == sse_pkg::PH_Q3 ##1 phase_q == sse_pkg::PH_Q4)
		else $error("quarter phases out of order");

	// bit 8 of the literal op is a don't-care, so both values must decode alike
	chk_lit_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q1 && !sleep_q
		 && instr_word[sse_pkg::LIT_PFX_MSB:sse_pkg::LIT_PFX_LSB] == sse_pkg::LIT_PFX)
		|=> op_q == sse_pkg::OP_LIT && ir_q[7:0] == $past(instr_word[7:0]))
		else $error("literal op not decoded");

	// status must hold still between subtracts; a stray write would corrupt later branches
	chk_flags_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q != sse_pkg::PH_Q4 || op_q == sse_pkg::OP_NONE) |=> $stable(flags_q))
		else $error("flags changed outside a subtract");

	chk_half_borrow: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(phase_q == sse_pkg::PH_Q3 && op_q != sse_pkg::OP_NONE)
		|=> ##1 flags_q.half_borrow_inverse_flag
		        == ($past(operand_q[3:0], 2) >= $past(acc_q[3:0], 2)))
		else $error("half borrow flag wrong");

	// while asleep the sequencer must stay parked so no instruction is taken
	chk_sleep_park: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sleep_q |-> phase_q == sse_pkg::PH_Q1)
		else $error("phase moved while asleep");

endmodule
`default_nettype wire

// >>> sse_exec_tb.sv
// self-checking testbench for the subtract and sleep execution block
`timescale 1ns/1ps
`default_nettype none
module sse_exec_tb;
	logic                        ref_clk       = 1'b0;
	logic                        reset_n       = 1'b0;
	logic [sse_pkg::INSTR_W-1:0] instr_word    = 14'h0000;
	logic                        acc_load_en   = 1'b0;
	logic [sse_pkg::DATA_W-1:0]  acc_load_data = 8'h00;
	logic [sse_pkg::DATA_W-1:0]  file_rdata    = 8'h00;
	logic                        wake          = 1'b0;
	logic [sse_pkg::FADDR_W-1:0] file_addr;
	logic [sse_pkg::DATA_W-1:0]  file_wdata;
	logic                        file_we;
	logic [sse_pkg::DATA_W-1:0]  acc;
	sse_pkg::sse_flags_t         flags;
	logic                        sleep_active;
	sse_pkg::sse_phase_t         quarter;
	logic [2:0]                  exp_flags;
	int                          bad_count     = 0;
	int                          check_count   = 0;
	int                          cycles        = 0;

	sse_exec DUT (.ref_clk, .reset_n, .instr_word, .acc_load_en, .acc_load_data,
		.file_rdata, .wake, .file_addr, .file_wdata, .file_we, .acc, .flags,
		.sleep_active, .quarter);

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	// hang guard: the planned run needs under 2000 cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			bad_count = bad_count + 1;
			tally_and_finish();
		end
	end

	// expected {carry, half borrow inverse, zero, difference} of m - s
	function automatic logic [10:0] sub_model(input logic [7:0] m, input logic [7:0] s);
		logic [7:0] d;
		d = m - s;
		return {(m >= s), (m[3:0] >= s[3:0]), (d == 8'h00), d};
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expected);
		check_count++;
		if (seen !== expected) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, expected, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// reads the phase that the edge just ended; bounded so a stuck phase counter shows up
	task automatic wait_old(input sse_pkg::sse_phase_t ph);
		int n;
		n = 0;
		@(posedge ref_clk);
		while (quarter !== ph && n < 8) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 8) check("phase wait", 16'h0000, 16'h0001);
	endtask

	// preload acc during an idle slot, then issue one word and check Q4 and the write-back
	task automatic run(input logic [13:0] w, input logic [7:0] frd, input logic [7:0] a);
		logic [10:0] r;
		logic        is_lit;
		logic        is_file;
		logic        is_slp;
		logic        dest;
		is_lit  = (w[13:9] == 5'h1e);
		is_file = (w[13:8] == 6'h02);
		is_slp  = (w == 14'h0063);
		dest    = w[7];
		r       = sub_model(is_lit ? w[7:0] : frd, a);
		wait_old(sse_pkg::PH_Q2);
		acc_load_en   <= 1'b1;
		acc_load_data <= a;
		@(posedge ref_clk);
		acc_load_en <= 1'b0;
		@(posedge ref_clk);
		instr_word <= w;
		file_rdata <= frd;
		repeat (3) @(posedge ref_clk);
		#1;
		check("quarter", quarter, sse_pkg::PH_Q4);
		check("file_we", file_we, is_file & dest);
		check("early sleep", sleep_active, 1'b0);
		if (is_file & dest) begin
			check("file_addr", file_addr, w[6:0]);
			check("file_wdata", file_wdata, r[7:0]);
		end
		@(posedge ref_clk);
		instr_word <= 14'h0000;
		#1;
		if (is_lit | is_file) exp_flags = r[10:8];
		check("acc", acc, (is_lit | (is_file & ~dest)) ? r[7:0] : a);
		check("flags", flags, exp_flags);
		check("sleep_active", sleep_active, is_slp);
	endtask

	// main sequence: worked cases, random mix, then sleep and wake
	initial begin
		logic [13:0] w;
		int          k;
		exp_flags = sse_pkg::FLAGS_RESET;
		k = $urandom(32'h88ad_3d9f);
		@(posedge ref_clk);
		#1;
		check("reset acc", acc, 8'h00);
		check("reset quarter", quarter, sse_pkg::PH_Q1);
		check("reset flags", flags, 3'h0);
		@(posedge ref_clk);
		reset_n <= 1'b1;
		run(14'h3c02, 8'h00, 8'h01);
		run(14'h3d02, 8'h00, 8'h02);
		run(14'h3c02, 8'h00, 8'h03);
		run(14'h3c10, 8'h00, 8'h01);
		run(14'h3c00, 8'h00, 8'hff);
		run(14'h0285, 8'h03, 8'h02);
		run(14'h0205, 8'h02, 8'h02);
		run(14'h02ff, 8'h01, 8'h02);
		run(14'h1234, 8'h77, 8'h11);
		for (int i = 0; i < 150; i++) begin
			k = $urandom_range(3);
			w = 14'($urandom);
			case (k)
				0: w = {5'h1e, w[8:0]};
				1: w = {6'h02, w[7:0]};
				default: w = {2'b01, w[11:0]};
			endcase
			run(w, 8'($urandom), 8'($urandom));
		end
		run(14'h0063, 8'h00, 8'h5a);
		repeat (5) begin
			@(posedge ref_clk);
			#1;
			check("parked quarter", quarter, sse_pkg::PH_Q1);
		end
		check("still asleep", sleep_active, 1'b1);
		@(posedge ref_clk);
		wake <= 1'b1;
		@(posedge ref_clk);
		wake <= 1'b0;
		#1;
		check("woken", sleep_active, 1'b0);
		run(14'h3c80, 8'h00, 8'h7f);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> sse_pkg.sv
// constants, types and decode functions for the subtract and sleep execution block
`default_nettype none
package sse_pkg;

	localparam int DATA_W  = 8;
	localparam int INSTR_W = 14;
	localparam int FADDR_W = 7;
	localparam int NIB_W   = 4;

	// instruction field positions
	localparam int LIT_PFX_MSB  = 13;
	localparam int LIT_PFX_LSB  = 9;
	localparam int FILE_PFX_MSB = 13;
	localparam int FILE_PFX_LSB = 8;
	localparam int DEST_BIT     = 7;

	// opcode patterns
	localparam logic [4:0]         LIT_PFX    = 5'h1e;
	localparam logic [5:0]         FILE_PFX   = 6'h02;
	localparam logic [INSTR_W-1:0] SLEEP_CODE = 14'h0063;

	// reset values
	localparam logic [DATA_W-1:0]  ACC_RESET   = 8'h00;
	localparam logic [DATA_W-1:0]  DATA_RESET  = 8'h00;
	localparam logic [INSTR_W-1:0] INSTR_RESET = 14'h0000;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} sse_phase_t;

	typedef enum logic [1:0] {OP_NONE, OP_LIT, OP_FILE} sse_op_t;

	typedef struct packed {
		logic carry;
		logic half_borrow_inverse_flag;
		logic zero;
	} sse_flags_t;

	localparam sse_flags_t FLAGS_RESET = '{carry: 1'b0, half_borrow_inverse_flag: 1'b0, zero: 1'b0};

	// literal_minus_acc_op: 11 110x kkkk kkkk
	function automatic logic is_lit_op(input logic [INSTR_W-1:0] w);
		return w[LIT_PFX_MSB:LIT_PFX_LSB] == LIT_PFX;
	endfunction

	// file_minus_acc_op: 00 0010 dfff ffff
	function automatic logic is_file_op(input logic [INSTR_W-1:0] w);
		return w[FILE_PFX_MSB:FILE_PFX_LSB] == FILE_PFX;
	endfunction

	function automatic logic is_sleep_op(input logic [INSTR_W-1:0] w);
		return w == SLEEP_CODE;
	endfunction

endpackage
`default_nettype wire

// >>> sse_subtractor.sv
// combinational 8-bit subtractor with carry, half-borrow and zero flags
`timescale 1ns/1ps
`default_nettype none
module sse_subtractor (
	input  wire logic [sse_pkg::DATA_W-1:0] minuend,
	input  wire logic [sse_pkg::DATA_W-1:0] subtrahend,
	output logic      [sse_pkg::DATA_W-1:0] difference,
	output sse_pkg::sse_flags_t             flags
);

	logic [sse_pkg::DATA_W:0]  wide_sum;
	logic [sse_pkg::NIB_W:0]   nib_sum;

	// add the two's complement of the subtrahend; the carry out is the inverted borrow
	always_comb begin
		wide_sum   = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
		nib_sum    = {1'b0, minuend[sse_pkg::NIB_W-1:0]}
		           + {1'b0, ~subtrahend[sse_pkg::NIB_W-1:0]} + 5'h01;
		difference = wide_sum[sse_pkg::DATA_W-1:0];
		flags.carry = wide_sum[sse_pkg::DATA_W];
		flags.half_borrow_inverse_flag = nib_sum[sse_pkg::NIB_W];
		flags.zero = (wide_sum[sse_pkg::DATA_W-1:0] == sse_pkg::DATA_RESET);
	end

endmodule
`default_nettype wire
